// ---- logic/bsl_pkg.sv ----
// Purpose: constants for the boot strap latch
// Assumes: APB slave with 32-bit data, 250 MHz core clock
// Notes: offsets are byte addresses of aligned words
package bsl_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] BSL_OFS_STRAP = 8'h00;
  localparam logic [7:0] BSL_OFS_BOOT = 8'h04;
  localparam logic [7:0] BSL_OFS_POLICY = 8'h08;
  // ==========================================================
  // field positions in the strap status word
  localparam int BSL_BIT_AUX = 0;
  localparam int BSL_BIT_PRINT = 1;
  localparam int BSL_BIT_BOOTSEL = 2;
  // boot status word fields
  localparam int BSL_BIT_SPI = 0;
  localparam int BSL_BIT_DL = 1;
  localparam int BSL_BIT_INVALID = 2;
  localparam int BSL_BIT_LOG = 3;
  localparam int BSL_BIT_LATCHED = 4;
  // ==========================================================
  // reset values
  localparam logic [1:0] BSL_POLICY_RST = 2'h0;
  localparam logic [2:0] BSL_STRAP_RST = 3'h4;
  // ==========================================================
  // timing: strap hold window after enable rises
  localparam int BSL_CLK_MHZ = 250;
  localparam int BSL_HOLD_MS = 3;
  localparam int BSL_HOLD_CYC = BSL_HOLD_MS * 1000 * BSL_CLK_MHZ;
  // log policy codes
  typedef enum logic [1:0] {
    BSL_LOG_ON = 2'b00,
    BSL_LOG_IF_LOW = 2'b01,
    BSL_LOG_IF_HIGH = 2'b10,
    BSL_LOG_OFF = 2'b11
  } bsl_log_t;
endpackage

// ---- logic/bsl_pin_sync.sv ----
// Purpose: hand-off of strap pins between sampling and normal use
// Assumes: pins are synchronous to the clock
// Notes: pull-up on boot-select folded in as the undriven level
`timescale 1ns/1ns
module bsl_pin_sync
  import bsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] pin_in,
  input wire logic [2:0] pin_driven,
  input wire logic sampling,
  output logic [2:0] pin_level,
  output logic [2:0] func_in
);
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] func;
  } bsl_pst_t;
  bsl_pst_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.level = pin_in;
    // undriven boot-select reads high through its pull-up
    if (!pin_driven[BSL_BIT_BOOTSEL]) begin
      s_nxt.level[BSL_BIT_BOOTSEL] = 1'b1;
    end
    // function path stays quiet while the pins serve as straps
    s_nxt.func = sampling ? 3'h0 : s_nxt.level;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{level: BSL_STRAP_RST, func: 3'h0};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign pin_level = s_r.level;
  assign func_in = s_r.func;
endmodule

// ---- logic/bsl_top.sv ----
// Purpose: strap latch, boot decoder and log-print enable with APB access
// Assumes: RST is any system reset; CHIP_EN low means powered off
// Notes: straps are caught continuously while enable is low and through the hold window
//   a reset with enable high acts as a fresh enable rise and reloads the fuse policy
//   a software policy write lasts until the next enable rise
//
// Notes on behaviour
// - on every system reset sample each strap pin, keep until power-down.
// - boot-select strap reads 1 when left undriven (internal pull-up).
// - after reset the strap pins return to normal function, latch unchanged.
// - software reads the three latched strap bits in a status register.
// - aux and boot-select high gives SPI boot; aux, print high, select low: download.
// - two-bit policy: 0 on, 1 on if print low, 2 on if high, 3 off.
// - device runs while enable is high, stays off while it is low.
`timescale 1ns/1ns
module bsl_top
  import bsl_pkg::*;
#(
  parameter int HOLD_CYC = BSL_HOLD_CYC
)(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CHIP_EN,
  input wire logic [2:0] STRAP_PIN_IN,
  input wire logic [2:0] STRAP_PIN_DRIVEN,
  input wire logic [1:0] LOG_POLICY,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [2:0] STRAP_FUNC_IN,
  output logic BOOT_SPI,
  output logic BOOT_DOWNLOAD,
  output logic BOOT_LOG_EN,
  output logic STRAP_VALID
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0] strap;
    logic latched;
    logic sampling;
    logic [31:0] hold_cnt;
    logic [1:0] policy;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic spi;
    logic dl;
    logic log_en;
    logic en_q;
  } bsl_st_t;
  // reset image: straps at their pull defaults, sampling armed, bus idle
  localparam bsl_st_t st_rst = '{
    strap: BSL_STRAP_RST,
    latched: 1'b0,
    sampling: 1'b1,
    hold_cnt: 32'h0,
    policy: BSL_POLICY_RST,
    rdata: 32'h0,
    ready: 1'b0,
    slverr: 1'b0,
    spi: 1'b0,
    dl: 1'b0,
    log_en: 1'b0,
    en_q: 1'b0
  };
  bsl_st_t s_r, s_nxt;
  logic [2:0] pin_level;
  logic [2:0] func_in;
  logic in_reset;
  logic en_rise;
  logic hold_done;
  logic access;
  logic nxt_aux;
  logic nxt_print;
  logic nxt_sel;
  logic strap_invalid;
  logic addr_hit;
  logic [31:0] rd_word;
  logic [31:0] word_strap;
  logic [31:0] word_boot;
  logic [31:0] word_policy;
  bsl_log_t pol;
  // ==========================================================
  // pin hand-off
  bsl_pin_sync u_pins (
    .clk(CORE_CLK),
    .rst(RST),
    .pin_in(STRAP_PIN_IN),
    .pin_driven(STRAP_PIN_DRIVEN),
    .sampling(s_r.sampling),
    .pin_level(pin_level),
    .func_in(func_in)
  );
  // ==========================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    in_reset = !CHIP_EN;
    en_rise = CHIP_EN && !s_r.en_q;
    hold_done = s_r.hold_cnt >= 32'(HOLD_CYC - 1);
    access = PSEL && PENABLE && !s_r.ready;
    pol = bsl_log_t'(s_r.policy);
    s_nxt.en_q = CHIP_EN;
    // ==========================================================
    // strap capture
    // enable low: device off, latch open and cleared
    if (in_reset) begin
      s_nxt.latched = 1'b0;
      s_nxt.sampling = 1'b1;
      s_nxt.hold_cnt = 32'h0;
      s_nxt.strap = pin_level;
    end else if (s_r.sampling) begin
      // track the straps through the hold window, then freeze
      s_nxt.strap = pin_level;
      if (hold_done) begin
        s_nxt.sampling = 1'b0;
        s_nxt.latched = 1'b1;
      end else begin
        s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
      end
    end
    // ==========================================================
    // boot decode
    nxt_aux = s_nxt.strap[BSL_BIT_AUX];
    nxt_print = s_nxt.strap[BSL_BIT_PRINT];
    nxt_sel = s_nxt.strap[BSL_BIT_BOOTSEL];
    // spi boot ignores the print strap
    s_nxt.spi = nxt_aux && nxt_sel;
    s_nxt.dl = nxt_aux && nxt_print && !nxt_sel;
    // log print gate
    unique case (pol)
      BSL_LOG_ON: s_nxt.log_en = 1'b1;
      BSL_LOG_IF_LOW: s_nxt.log_en = !nxt_print;
      BSL_LOG_IF_HIGH: s_nxt.log_en = nxt_print;
      BSL_LOG_OFF: s_nxt.log_en = 1'b0;
    endcase
    // ==========================================================
    // register words, rebuilt each cycle from the live state
    word_strap = 32'h0;
    word_strap[BSL_BIT_AUX] = s_r.strap[BSL_BIT_AUX];
    word_strap[BSL_BIT_PRINT] = s_r.strap[BSL_BIT_PRINT];
    word_strap[BSL_BIT_BOOTSEL] = s_r.strap[BSL_BIT_BOOTSEL];
    // print and select both low is not a legal strap set
    strap_invalid = !s_r.strap[BSL_BIT_PRINT] && !s_r.strap[BSL_BIT_BOOTSEL];
    word_boot = 32'h0;
    word_boot[BSL_BIT_SPI] = s_r.spi;
    word_boot[BSL_BIT_DL] = s_r.dl;
    word_boot[BSL_BIT_INVALID] = strap_invalid;
    word_boot[BSL_BIT_LOG] = s_r.log_en;
    word_boot[BSL_BIT_LATCHED] = s_r.latched;
    word_policy = 32'h0;
    word_policy[1:0] = s_r.policy;
    // ==========================================================
    // address decode
    addr_hit = 1'b1;
    rd_word = 32'h0;
    unique case (PADDR)
      BSL_OFS_STRAP: begin
        rd_word = word_strap;
      end
      BSL_OFS_BOOT: begin
        rd_word = word_boot;
      end
      BSL_OFS_POLICY: begin
        rd_word = word_policy;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    // ==========================================================
    // apb slave: one wait state, answer in the cycle after access
    s_nxt.ready = access;
    s_nxt.slverr = 1'b0;
    if (access) begin
      // unmapped words answer zero with an error
      s_nxt.slverr = !addr_hit;
      if (!PWRITE) begin
        s_nxt.rdata = rd_word;
      end else begin
        s_nxt.rdata = 32'h0;
      end
      // only the policy word takes writes; status words ignore them
      if (PWRITE && PADDR == BSL_OFS_POLICY) begin
        s_nxt.policy = PWDATA[1:0];
      end
    end
    // ==========================================================
    // fuse policy
    // each enable rise reloads the fuse field and beats a write in the same cycle
    if (en_rise) begin
      s_nxt.policy = LOG_POLICY;
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_r <= st_rst;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ==========================================================
  // outputs
  assign PRDATA = s_r.rdata;
  assign PREADY = s_r.ready;
  assign PSLVERR = s_r.slverr;
  assign STRAP_FUNC_IN = func_in;
  assign BOOT_SPI = s_r.spi;
  assign BOOT_DOWNLOAD = s_r.dl;
  assign BOOT_LOG_EN = s_r.log_en;
  assign STRAP_VALID = s_r.latched;
endmodule

// ---- tb/bsl_checker.sv ----
// Purpose: port checks of the strap latch
// Assumes: HOLD_CYC of at least 8
// Notes: bound into bsl_top
`timescale 1ns/1ns
module bsl_checker #(parameter int HOLD_CYC = 16)(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CHIP_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [2:0] STRAP_FUNC_IN,
  input wire logic BOOT_SPI,
  input wire logic BOOT_DOWNLOAD,
  input wire logic STRAP_VALID
);
  localparam int VMAX = HOLD_CYC + 4;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // ==========
  // strap read with a settled latch
  sequence s_rd0;
    PREADY && !PWRITE && PADDR == 8'h00 && STRAP_VALID && $past(STRAP_VALID);
  endsequence
  property p_ack; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_ack: assert property (p_ack) else $error("ready late");
  property p_err; PREADY |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08}); endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_zero; PREADY && !PWRITE && PADDR == 8'h00 |-> PRDATA[31:3] == 29'h0; endproperty
  a_zero: assert property (p_zero) else $error("upper bits set");
  property p_spi; s_rd0 |-> BOOT_SPI == (PRDATA[0] && PRDATA[2]); endproperty
  a_spi: assert property (p_spi) else $error("spi decode");
  property p_dl; s_rd0 |-> BOOT_DOWNLOAD == (PRDATA[0] && PRDATA[1] && !PRDATA[2]); endproperty
  a_dl: assert property (p_dl) else $error("download decode");
  property p_func; !STRAP_VALID && !$past(STRAP_VALID) |-> STRAP_FUNC_IN == 3'h0; endproperty
  a_func: assert property (p_func) else $error("pins live while sampling");
  property p_off; !CHIP_EN ##1 !CHIP_EN |=> !STRAP_VALID; endproperty
  a_off: assert property (p_off) else $error("valid while off");
  property p_hold; $rose(CHIP_EN) |-> !STRAP_VALID [*8] ##[1:VMAX] STRAP_VALID; endproperty
  a_hold: assert property (p_hold) else $error("hold window");
endmodule
bind bsl_top bsl_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (.CORE_CLK, .RST, .CHIP_EN, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .STRAP_FUNC_IN, .BOOT_SPI, .BOOT_DOWNLOAD, .STRAP_VALID);

// ---- tb/bsl_strap_model.sv ----
// Purpose: board drivers on the strap pins
// Assumes: drv high while the board drives a pin
// Notes: a released pin toggles every cycle
`timescale 1ns/1ns
module bsl_strap_model (
  input wire logic clk,
  input wire logic [2:0] lvl,
  input wire logic [2:0] drv,
  output logic [2:0] pin,
  output logic [2:0] pin_drv
);
  logic [2:0] last_r = 3'h0;
  always @(posedge clk) last_r <= pin;
  assign pin = (drv & lvl) | (~drv & ~last_r);
  assign pin_drv = drv;
endmodule

// ---- tb/boot_strap_latch_bench.sv ----
// Purpose: self-checking bench of the strap latch
// Assumes: HOLD_CYC shortened to 16
// Notes: bus answers checked against a queue of notes
`timescale 1ns/1ns
module boot_strap_latch_bench
  import bsl_pkg::*;
;
  logic clk = 0, rst = 1, en = 0, psel = 0, pen = 0, pwr = 0, rdy, err, spi, dl, lg, vld;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd;
  logic [1:0] pol = 2'h3;
  logic [2:0] lvl = 3'h0, drv = 3'h7, pin, pdrv, func, s;
  logic [33:0] q[$], e_m;
  int err_total = 0, num_checks = 0, cyc = 0, seed = 32'hbd061ea1;
  always #2 clk = ~clk;
  bsl_strap_model brd (.clk(clk), .lvl(lvl), .drv(drv), .pin(pin), .pin_drv(pdrv));
  bsl_top #(.HOLD_CYC(16)) dut (.CORE_CLK(clk), .RST(rst), .CHIP_EN(en), .STRAP_PIN_IN(pin),
    .STRAP_PIN_DRIVEN(pdrv), .LOG_POLICY(pol), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .STRAP_FUNC_IN(func), .BOOT_SPI(spi),
    .BOOT_DOWNLOAD(dl), .BOOT_LOG_EN(lg), .STRAP_VALID(vld));
  function logic [31:0] bw(logic [1:0] m);
    return {28'h1, m == 2'h0 || (m == 2'h1 && !s[1]) || (m == 2'h2 && s[1]), 1'b0, s[0] & s[1] & ~s[2], s[0] & s[2]};
  endfunction
  task end_of_test();
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
    q.push_back(e);
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    {psel, pen} <= 2'b00;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    apb(0, a, 32'h0, {2'b10, e});
  endtask
  always @(posedge clk) begin
    if (rdy === 1'b1) begin
      e_m = q.pop_front();
      chk("pslverr", {31'h0, e_m[32]}, {31'h0, err});
      if (e_m[33]) chk("prdata", e_m[31:0], prd);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rd(BSL_OFS_POLICY, {30'h0, BSL_POLICY_RST});
    apb(0, 8'h0C, 32'h0, {2'b11, 32'h0});
    for (int i = 0; i < 16; i++) begin
      s = i[2:0];
      if (s[2:1] == 2'h0) continue;
      pol <= 2'($random(seed));
      lvl <= {s[2] & ~i[3], s[1:0]};
      drv <= {~(s[2] & i[3]), 2'h3};
      {en, rst} <= 2'b01;
      @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      en <= 1;
      repeat (20) @(posedge clk);
      lvl <= 3'($random(seed));
      drv <= 3'h7;
      repeat (3) @(posedge clk);
      chk("func", {29'h0, lvl}, {29'h0, func});
      chk("boot_pins", bw(pol), {27'h0, vld, lg, 1'b0, dl, spi});
      rd(BSL_OFS_STRAP, {29'h0, s});
      rd(BSL_OFS_BOOT, bw(pol));
      apb(1, BSL_OFS_STRAP, 32'hFFFFFFFF, 34'h0);
      apb(1, BSL_OFS_POLICY, {30'h0, ~pol}, 34'h0);
      rd(BSL_OFS_POLICY, {30'h0, ~pol});
      rd(BSL_OFS_STRAP, {29'h0, s});
      rd(BSL_OFS_BOOT, bw(~pol));
      chk("boot_pins", bw(~pol), {27'h0, vld, lg, 1'b0, dl, spi});
    end
    end_of_test();
  end
endmodule
